// ---- rtl/cpuctl_pkg.sv ----
// Purpose: constants for the CPU control state and memory map block
// Assumes: 10 MHz core clock, APB register access
// Notes:
// Behaviour
// - Flat 64 KB space decoded with 16-bit addresses for fetch and data.
// - Vector area is lowest 30 bytes; entries low byte even, high byte odd.
// - Vectors: reset, watchdog, four pins, serial, two byte timers, two word timers.
// - Slot 001CH belongs to no source; no request branches through it.
// - Table call takes its entry from the 64-byte table 0040H to 007FH.
// - Program memory 16384 bytes mask variant, 32768 flash, from zero.
// - High-speed RAM at FD00H to FEFFH, also the stack region.
// - Display RAM at FA00H to FA19H, also usable as data memory.
// - Special registers in 256-byte window FF00H to FFFFH.
// - Program counter advances by instruction length, loads on branch.
// - Reset loads program counter from vector bytes 0000H and 0001H.
// - Status word pushed on interrupt or push, restored on return or pop.
// - Reset forces status word to 02H.
// - Enable flag clear refuses maskable requests; set allows per-source mask.
// - Enable flag cleared by disable and acknowledge, set by enable.
// - Zero flag on zero result; half carry on bit 3 carry or borrow.
// - Carry holds add/subtract overflow, rotate shift-out, bit accumulator.
// - Stack pointer decremented before write, incremented after read.
// - Stack pointer undefined after reset; software initialises it.
// - Eight byte registers, usable singly or as four pairs, two numberings.

package cpuctl_pkg;

	localparam int ADDR_W = 16;
	localparam logic [15:0] VEC_RESET    = 16'h0000;
	localparam logic [15:0] VEC_WDT      = 16'h0004;
	localparam logic [15:0] VEC_PIN0     = 16'h0006;
	localparam logic [15:0] VEC_SER_ERR  = 16'h000E;
	localparam logic [15:0] VEC_SER_RX   = 16'h0010;
	localparam logic [15:0] VEC_SER_TX   = 16'h0012;
	localparam logic [15:0] VEC_BTIM_A   = 16'h0014;
	localparam logic [15:0] VEC_BTIM_B   = 16'h0016;
	localparam logic [15:0] VEC_WTIM_A   = 16'h0018;
	localparam logic [15:0] VEC_WTIM_B   = 16'h001A;
	localparam logic [15:0] VEC_UNUSED   = 16'h001C;
	localparam logic [15:0] VEC_AREA_END = 16'h001D;
	localparam logic [15:0] TABLE_CALL_INSTR_LO     = 16'h0040;
	localparam logic [15:0] TABLE_CALL_INSTR_HI     = 16'h007F;
	localparam logic [15:0] ROM_MASK_SZ  = 16'h4000;
	localparam logic [16:0] ROM_FLASH_SZ = 17'h0_8000;
	localparam logic [15:0] HRAM_LO      = 16'hFD00;
	localparam logic [15:0] HRAM_HI      = 16'hFEFF;
	localparam logic [15:0] DRAM_LO      = 16'hFA00;
	localparam logic [15:0] DRAM_HI      = 16'hFA19;
	localparam logic [15:0] SFR_LO       = 16'hFF00;
	localparam logic [15:0] ONE16        = 16'h0001;
	localparam logic [15:0] TWO16        = 16'h0002;

	// Status word layout
	localparam logic [7:0] PSW_RESET = 8'h02;
	localparam int BIT_CY = 0;
	localparam int BIT_ONE = 1;
	localparam int BIT_AC = 4;
	localparam int BIT_Z  = 6;
	localparam int BIT_IE = 7;

	// APB register byte addresses
	localparam logic [7:0] OFS_PC     = 8'h00;
	localparam logic [7:0] OFS_PSW    = 8'h04;
	localparam logic [7:0] OFS_SP     = 8'h08;
	localparam logic [7:0] OFS_CMD    = 8'h0C;
	localparam logic [7:0] OFS_ARG    = 8'h10;
	localparam logic [7:0] OFS_STAT   = 8'h14;
	localparam logic [7:0] OFS_MAP    = 8'h18;
	localparam logic [7:0] OFS_RESULT = 8'h1C;
	localparam logic [7:0] OFS_GPR0   = 8'h20;
	localparam logic [7:0] OFS_GPR1   = 8'h24;
	localparam logic [7:0] OFS_PAIR   = 8'h28;

	// Command codes written to the command register
	typedef enum logic [3:0] {
		CPUCTL_NOP, CPUCTL_ADVANCE, CPUCTL_BRANCH, CPUCTL_TABLE_CALL_INSTR, CPUCTL_IRQ,
		CPUCTL_RETURN_FROM_IRQ_INSTR, CPUCTL_PUSH_PSW, CPUCTL_POP_PSW, CPUCTL_EI, CPUCTL_DI,
		CPUCTL_ADD, CPUCTL_SUB, CPUCTL_ROTL, CPUCTL_SET1CY, CPUCTL_CLR1CY,
		CPUCTL_BOOT
	} cpuctl_cmd_t;

	localparam int SRC_N = 12;

endpackage : cpuctl_pkg

// ---- rtl/cpuctl_top.sv ----
// Purpose: CPU control state (program counter, status word, stack pointer,
//          general registers) and fixed memory map decoder
// Assumes: APB slave, zero wait states, vector bytes arrive on VEC_* ports
// Notes:   Commands are single-cycle; the stack is a small local array
//
// Design decisions made here: the register addresses and register access over APB.

`timescale 1ns/1ps

module cpuctl_top
	import cpuctl_pkg::*;
#(
	parameter bit FLASH_VARIANT = 1'b0,
	parameter int STACK_DEPTH  = 512
) (
	input  wire logic        CLOCK,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [7:0]  VEC_LOW,
	input  wire logic [7:0]  VEC_HIGH,
	input  wire logic [11:0] IRQ_REQ,
	input  wire logic [11:0] IRQ_MASK,
	output logic      [15:0] FETCH_ADDR,
	output logic             IRQ_TAKEN
);

	////////////////////////////////////////////////////////////////////////
	logic [15:0] program_address_counter;
	logic [7:0]  processor_flag_word;
	logic [15:0] stack_top_pointer;
	logic [7:0]  gpr [8];
	logic [7:0]  stack_mem [STACK_DEPTH];
	logic [15:0] map_addr;
	logic [15:0] arg;
	logic [7:0]  result;
	logic        booted;
	logic        bad_sp;

	wire access   = PSEL && PENABLE;
	wire wr       = access && PWRITE;
	wire wr_cmd   = wr && (PADDR == OFS_CMD);
	wire [3:0] cmd_code = PWDATA[3:0];
	wire interrupt_accept_flag = processor_flag_word[BIT_IE];
	wire half_carry_flag       = processor_flag_word[BIT_AC];
	wire carry_out_flag        = processor_flag_word[BIT_CY];

	wire known = (PADDR == OFS_PC) || (PADDR == OFS_PSW) || (PADDR == OFS_SP) ||
		(PADDR == OFS_CMD) || (PADDR == OFS_ARG) || (PADDR == OFS_STAT) ||
		(PADDR == OFS_MAP) || (PADDR == OFS_RESULT) || (PADDR == OFS_GPR0) ||
		(PADDR == OFS_GPR1) || (PADDR == OFS_PAIR);

	////////////////////////////////////////////////////////////////////////
	// Memory map decode over the full 16-bit space
	wire [16:0] rom_size = FLASH_VARIANT ? ROM_FLASH_SZ : {1'b0, ROM_MASK_SZ};
	wire in_rom    = {1'b0, map_addr} < rom_size;
	wire in_vec    = map_addr <= VEC_AREA_END;
	wire in_table_call_instr  = (map_addr >= TABLE_CALL_INSTR_LO) && (map_addr <= TABLE_CALL_INSTR_HI);
	wire in_hram   = (map_addr >= HRAM_LO) && (map_addr <= HRAM_HI);
	wire in_dram   = (map_addr >= DRAM_LO) && (map_addr <= DRAM_HI);
	wire in_sfr    = map_addr >= SFR_LO;
	wire [6:0] map_flags = {in_rom, in_vec, in_table_call_instr, in_hram, in_dram, in_sfr,
		map_addr[0]};

	////////////////////////////////////////////////////////////////////////
	// Interrupt selection: lowest index wins, enable flag gates all
	wire [11:0] pending = IRQ_REQ & ~IRQ_MASK;
	logic [3:0] irq_idx;
	always_comb begin
		irq_idx = 4'h0;
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (pending[i]) begin
				irq_idx = 4'(i);
			end
		end
	end
	wire irq_ok = interrupt_accept_flag && (pending != 12'h000);
	// Index 0 is watchdog at 0004H, then 2 bytes apart; 001CH is never produced
	wire [15:0] irq_vec = VEC_WDT + {11'h000, irq_idx, 1'b0};

	////////////////////////////////////////////////////////////////////////
	// Arithmetic on gpr A (index 1) with arg low byte
	wire [8:0] add_full = {1'b0, gpr[1]} + {1'b0, arg[7:0]} + {8'h00, carry_out_flag};
	wire [8:0] sub_full = {1'b0, gpr[1]} - {1'b0, arg[7:0]};
	wire [4:0] add_nib  = {1'b0, gpr[1][3:0]} + {1'b0, arg[3:0]} + {4'h0, carry_out_flag};
	wire [4:0] sub_nib  = {1'b0, gpr[1][3:0]} - {1'b0, arg[3:0]};
	wire [15:0] sp_dec  = stack_top_pointer - ONE16;
	wire [15:0] sp_idx  = stack_top_pointer - HRAM_LO;
	wire [15:0] sp_wr   = sp_dec - HRAM_LO;
	wire [15:0] table_call_instr_addr = TABLE_CALL_INSTR_LO + {10'h000, arg[4:0], 1'b0};

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			program_address_counter <= 16'h0000;
			processor_flag_word     <= PSW_RESET;
			booted                  <= 1'b0;
			IRQ_TAKEN               <= 1'b0;
			result                  <= 8'h00;
		end else begin
			IRQ_TAKEN <= 1'b0;
			if (!booted) begin
				program_address_counter <= {VEC_HIGH, VEC_LOW};
				booted <= 1'b1;
			end else if (wr && PADDR == OFS_PC) begin
				program_address_counter <= PWDATA[15:0];
			end else if (wr && PADDR == OFS_PSW) begin
				processor_flag_word <= PWDATA[7:0];
			end else if (wr_cmd) begin
				case (cpuctl_cmd_t'(cmd_code))
					CPUCTL_ADVANCE:  program_address_counter <= program_address_counter + arg;
					CPUCTL_BRANCH:   program_address_counter <= arg;
					CPUCTL_TABLE_CALL_INSTR:    program_address_counter <= table_call_instr_addr;
					CPUCTL_BOOT:     program_address_counter <= {VEC_HIGH, VEC_LOW};
					CPUCTL_IRQ: begin
						if (irq_ok) begin
							program_address_counter <= irq_vec;
							processor_flag_word[BIT_IE] <= 1'b0;
							IRQ_TAKEN <= 1'b1;
						end
					end
					CPUCTL_RETURN_FROM_IRQ_INSTR, CPUCTL_POP_PSW: begin
						processor_flag_word <= stack_mem[sp_idx[8:0]];
						if (cmd_code == CPUCTL_RETURN_FROM_IRQ_INSTR) begin
							program_address_counter <= arg;
						end
					end
					CPUCTL_EI:  processor_flag_word[BIT_IE] <= 1'b1;
					CPUCTL_DI:  processor_flag_word[BIT_IE] <= 1'b0;
					CPUCTL_ADD: begin
						result <= add_full[7:0];
						processor_flag_word[BIT_Z]  <= (add_full[7:0] == 8'h00);
						processor_flag_word[BIT_AC] <= add_nib[4];
						processor_flag_word[BIT_CY] <= add_full[8];
					end
					CPUCTL_SUB: begin
						result <= sub_full[7:0];
						processor_flag_word[BIT_Z]  <= (sub_full[7:0] == 8'h00);
						processor_flag_word[BIT_AC] <= sub_nib[4];
						processor_flag_word[BIT_CY] <= sub_full[8];
					end
					CPUCTL_ROTL: begin
						result <= {gpr[1][6:0], gpr[1][7]};
						processor_flag_word[BIT_CY] <= gpr[1][7];
					end
					CPUCTL_SET1CY: processor_flag_word[BIT_CY] <=
						carry_out_flag & arg[0];
					CPUCTL_CLR1CY: processor_flag_word[BIT_CY] <=
						carry_out_flag | arg[0];
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stack pointer: no reset value on purpose, software must load it
	always_ff @(posedge CLOCK) begin
		if (wr && PADDR == OFS_SP) begin
			stack_top_pointer <= PWDATA[15:0];
		end else if (wr_cmd && (cmd_code == CPUCTL_PUSH_PSW ||
			(cmd_code == CPUCTL_IRQ && irq_ok))) begin
			stack_top_pointer <= sp_dec;
			stack_mem[sp_wr[8:0]] <= processor_flag_word;
		end else if (wr_cmd && (cmd_code == CPUCTL_POP_PSW ||
			cmd_code == CPUCTL_RETURN_FROM_IRQ_INSTR)) begin
			stack_top_pointer <= stack_top_pointer + ONE16;
		end
	end
	// Out-of-range pointer only flagged; software owns placement
	wire in_sp_ram = (stack_top_pointer > HRAM_LO) && (stack_top_pointer <= HRAM_HI + ONE16);
	assign bad_sp = !in_sp_ram;

	////////////////////////////////////////////////////////////////////////
	// General registers, absolute index 0..7; pair n is regs 2n (low), 2n+1
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < 8; i++) begin
				gpr[i] <= 8'h00;
			end
			map_addr <= 16'h0000;
			arg      <= 16'h0000;
		end else begin
			if (wr && PADDR == OFS_MAP) begin
				map_addr <= PWDATA[15:0];
			end
			if (wr && PADDR == OFS_ARG) begin
				arg <= PWDATA[15:0];
			end
			if (wr && PADDR == OFS_GPR0) begin
				for (int i = 0; i < 4; i++) begin
					gpr[i] <= PWDATA[i*8 +: 8];
				end
			end
			if (wr && PADDR == OFS_GPR1) begin
				for (int i = 0; i < 4; i++) begin
					gpr[i+4] <= PWDATA[i*8 +: 8];
				end
			end
			if (wr && PADDR == OFS_PAIR) begin
				gpr[{PWDATA[17:16], 1'b0}] <= PWDATA[7:0];
				gpr[{PWDATA[17:16], 1'b1}] <= PWDATA[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB read path and fixed zero-wait answer
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (PADDR)
			OFS_PC:     next_rdata = {16'h0000, program_address_counter};
			OFS_PSW:    next_rdata = {24'h00_0000, processor_flag_word};
			OFS_SP:     next_rdata = {16'h0000, stack_top_pointer};
			OFS_ARG:    next_rdata = {16'h0000, arg};
			OFS_STAT:   next_rdata = {28'h000_0000, bad_sp, irq_ok, half_carry_flag, booted};
			OFS_MAP:    next_rdata = {9'h000, map_flags, map_addr};
			OFS_RESULT: next_rdata = {24'h00_0000, result};
			OFS_GPR0:   next_rdata = {gpr[3], gpr[2], gpr[1], gpr[0]};
			OFS_GPR1:   next_rdata = {gpr[7], gpr[6], gpr[5], gpr[4]};
			default:    next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			PRDATA     <= 32'h0000_0000;
			PREADY     <= 1'b0;
			PSLVERR    <= 1'b0;
			FETCH_ADDR <= 16'h0000;
		end else begin
			PREADY     <= PSEL && !PENABLE;
			PSLVERR    <= PSEL && !PENABLE && !known;
			PRDATA     <= next_rdata;
			FETCH_ADDR <= program_address_counter;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_psw_reset: assert property (@(posedge CLOCK) $rose(RESETN) |->
		processor_flag_word == PSW_RESET) else $error("status word not 02H after reset");
	a_ie_refuse: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(wr_cmd && cmd_code == CPUCTL_IRQ && !interrupt_accept_flag) |=> !IRQ_TAKEN)
		else $error("interrupt taken while disabled");
	a_ie_clear: assert property (@(posedge CLOCK) disable iff (!RESETN)
		IRQ_TAKEN |-> !interrupt_accept_flag) else $error("enable flag kept on acknowledge");
	a_no_vec1c: assert property (@(posedge CLOCK) disable iff (!RESETN)
		IRQ_TAKEN |-> program_address_counter != VEC_UNUSED
		&& program_address_counter <= VEC_WTIM_B) else $error("bad vector");
	a_sp_push: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(wr_cmd && cmd_code == CPUCTL_PUSH_PSW && !(PADDR == OFS_SP)) |=>
		stack_top_pointer == $past(stack_top_pointer) - ONE16) else $error("push did not decrement");
	a_pc_branch: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(booted && wr_cmd && cmd_code == CPUCTL_BRANCH) |=> program_address_counter == $past(arg))
		else $error("branch not loaded");
	a_zero_flag: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(booted && wr_cmd && cmd_code == CPUCTL_ADD) |=>
		processor_flag_word[BIT_Z] == (result == 8'h00)) else $error("zero flag wrong");
	a_hram_map: assert property (@(posedge CLOCK) disable iff (!RESETN)
		in_hram |-> map_addr[15:9] == 7'h7E || map_addr[15:8] == 8'hFE
		|| map_addr[15:8] == 8'hFD) else $error("ram decode wrong");
	a_rst_boot: assert property (@(posedge CLOCK) disable iff (!RESETN)
		!booted |=> program_address_counter == $past({VEC_HIGH, VEC_LOW}))
		else $error("reset vector not loaded");
	a_ie_set: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(booted && wr_cmd && cmd_code == CPUCTL_EI) |=> interrupt_accept_flag)
		else $error("enable flag not set");
	a_ie_disable: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(booted && wr_cmd && cmd_code == CPUCTL_DI) |=> !interrupt_accept_flag)
		else $error("enable flag not cleared");
	a_sp_pop: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(wr_cmd && cmd_code == CPUCTL_POP_PSW) |=>
		stack_top_pointer == $past(stack_top_pointer) + ONE16) else $error("pop did not increment");
	a_table_call_instr_range: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(booted && wr_cmd && cmd_code == CPUCTL_TABLE_CALL_INSTR) |=>
		program_address_counter >= TABLE_CALL_INSTR_LO && program_address_counter <= TABLE_CALL_INSTR_HI)
		else $error("table call outside table");
	a_fetch_copy: assert property (@(posedge CLOCK) disable iff (!RESETN)
		booted |=> FETCH_ADDR == $past(program_address_counter))
		else $error("fetch address not the counter");
	a_vec_even: assert property (@(posedge CLOCK) disable iff (!RESETN)
		IRQ_TAKEN |-> !program_address_counter[0]) else $error("odd vector address");

endmodule : cpuctl_top

// ---- tb/cpuctl_tb_top.sv ----
// Purpose: self-checking bench for cpuctl_top, driven over APB
// Assumes: zero-wait slave, mask variant, map flags in bits 22:16 (rom high, odd low)
// Notes:   arithmetic results are checked only where the flag rules fix them

`timescale 1ns/1ps

module cpu_control_state_and_memory_map_tb_top
	import cpuctl_pkg::*;
;
	typedef struct {logic [15:0] a; logic [6:0] f;} cpuctl_row_t;

	logic        clock = 1'b0;
	logic        resetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  vec_low;
	logic [7:0]  vec_high;
	logic [11:0] irq_req;
	logic [11:0] irq_mask;
	logic [15:0] fetch_addr;
	logic        irq_taken;
	logic [31:0] q;
	logic        e;
	int          num_errors = 0;
	int          compares = 0;
	int          taken = 0;
	cpuctl_row_t rows [13] = '{'{16'h0000, 7'h60}, '{16'h001D, 7'h61}, '{16'h001E, 7'h40},
		'{16'h0040, 7'h50}, '{16'h007F, 7'h51}, '{16'h3FFF, 7'h41}, '{16'h4000, 7'h00},
		'{16'hFA19, 7'h05}, '{16'hFA1A, 7'h00}, '{16'hFD00, 7'h08}, '{16'hFEFF, 7'h09},
		'{16'hFF00, 7'h02}, '{16'hFFFF, 7'h03}};

	cpuctl_top dut (.CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .VEC_LOW(vec_low), .VEC_HIGH(vec_high), .IRQ_REQ(irq_req),
		.IRQ_MASK(irq_mask), .FETCH_ADDR(fetch_addr), .IRQ_TAKEN(irq_taken));

	always #50 clock = ~clock;

	// Pulse counter, so pulse timing need not be guessed
	always @(posedge clock) begin
		if (irq_taken === 1'b1) begin
			taken <= taken + 1;
		end
	end

	task automatic results();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		chk({31'h0000_0000, pready}, 32'h0000_0001);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic cmd(input cpuctl_cmd_t c, input logic [15:0] arg);
		apb(1'b1, OFS_ARG, {16'h0000, arg});
		apb(1'b1, OFS_CMD, {28'h000_0000, c});
	endtask : cmd

	initial begin
		#(100 * 40000);
		num_errors++;
		results();
	end

	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		vec_low = 8'h34;
		vec_high = 8'h12;
		irq_req = 12'h000;
		irq_mask = 12'hFFF;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q, 32'h0000_0002);
		apb(1'b0, OFS_PC, 32'h0000_0000);
		chk(q, 32'h0000_1234);
		chk({16'h0000, fetch_addr}, 32'h0000_1234);
		for (int i = 0; i < 13; i++) begin
			apb(1'b1, OFS_MAP, {16'h0000, rows[i].a});
			apb(1'b0, OFS_MAP, 32'h0000_0000);
			chk((q >> 16) & 32'h0000_007F, {25'h000_0000, rows[i].f});
		end
		// Unmapped offset must answer with an error and read zero
		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		cmd(CPUCTL_BRANCH, 16'h1000);
		cmd(CPUCTL_ADVANCE, 16'h0003);
		apb(1'b0, OFS_PC, 32'h0000_0000);
		chk(q, 32'h0000_1003);
		cmd(CPUCTL_TABLE_CALL_INSTR, 16'h0021);
		apb(1'b0, OFS_PC, 32'h0000_0000);
		chk(q, 32'h0000_0042);
		irq_req <= 12'h001;
		cmd(CPUCTL_IRQ, 16'h0000);
		cmd(CPUCTL_EI, 16'h0000);
		cmd(CPUCTL_IRQ, 16'h0000);
		apb(1'b0, OFS_PC, 32'h0000_0000);
		chk(q, 32'h0000_0042);
		chk(taken, 0);
		irq_mask <= 12'h000;
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, OFS_SP, 32'h0000_FE00);
			cmd(CPUCTL_EI, 16'h0000);
			irq_req <= 12'h001 << i;
			cmd(CPUCTL_IRQ, 16'h0000);
			apb(1'b0, OFS_PC, 32'h0000_0000);
			chk(q, 32'(4 + 2 * i));
			apb(1'b0, OFS_PSW, 32'h0000_0000);
			chk(q & 32'h0000_0080, 32'h0000_0000);
			apb(1'b0, OFS_SP, 32'h0000_0000);
			chk(q, 32'h0000_FDFF);
		end
		chk(taken, 12);
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		cmd(CPUCTL_RETURN_FROM_IRQ_INSTR, 16'h0100);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0080, 32'h0000_0080);
		apb(1'b0, OFS_SP, 32'h0000_0000);
		chk(q, 32'h0000_FE00);
		cmd(CPUCTL_PUSH_PSW, 16'h0000);
		cmd(CPUCTL_DI, 16'h0000);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0080, 32'h0000_0000);
		cmd(CPUCTL_POP_PSW, 16'h0000);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0080, 32'h0000_0080);
		apb(1'b1, OFS_PSW, 32'h0000_0000);
		apb(1'b1, OFS_GPR0, 32'h0000_0F00);
		cmd(CPUCTL_ADD, 16'h0001);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0051, 32'h0000_0010);
		apb(1'b0, OFS_RESULT, 32'h0000_0000);
		chk(q, 32'h0000_0010);
		// Result lands in its own register, the operand register stays 0FH
		cmd(CPUCTL_ADD, 16'h00F1);
		apb(1'b0, OFS_RESULT, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0051, 32'h0000_0051);
		apb(1'b1, OFS_PSW, 32'h0000_0000);
		apb(1'b1, OFS_GPR0, 32'h0000_8100);
		cmd(CPUCTL_ROTL, 16'h0000);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0001, 32'h0000_0001);
		cmd(CPUCTL_SET1CY, 16'h0000);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0001, 32'h0000_0000);
		cmd(CPUCTL_CLR1CY, 16'h0001);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0001, 32'h0000_0001);
		apb(1'b1, OFS_PSW, 32'h0000_0000);
		cmd(CPUCTL_SUB, 16'h0081);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q & 32'h0000_0051, 32'h0000_0040);
		cmd(CPUCTL_BOOT, 16'h0000);
		apb(1'b0, OFS_PC, 32'h0000_0000);
		chk(q, 32'h0000_1234);
		apb(1'b1, OFS_PAIR, 32'h0003_BEEF);
		apb(1'b1, OFS_PAIR, 32'h0000_1234);
		apb(1'b0, OFS_GPR1, 32'h0000_0000);
		chk(q & 32'hFFFF_0000, 32'hBEEF_0000);
		apb(1'b0, OFS_GPR0, 32'h0000_0000);
		chk(q & 32'h0000_FFFF, 32'h0000_1234);
		apb(1'b1, OFS_SP, 32'h0000_0100);
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(q & 32'h0000_0008, 32'h0000_0008);
		// Second reset in mid-run, with a new vector
		apb(1'b1, OFS_PSW, 32'h0000_00FF);
		vec_low <= 8'h78;
		vec_high <= 8'h56;
		resetn <= 1'b0;
		@(posedge clock);
		#1;
		chk({31'h0000_0000, pready}, 32'h0000_0000);
		@(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
		apb(1'b0, OFS_PSW, 32'h0000_0000);
		chk(q, 32'h0000_0002);
		apb(1'b0, OFS_PC, 32'h0000_0000);
		chk(q, 32'h0000_5678);
		results();
	end
endmodule : cpu_control_state_and_memory_map_tb_top
